// file: logic/hsf_pkg.sv
package hsf_pkg;
  // Timing
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned SAMPLE_HZ      = 8_000;
  localparam int unsigned WAKE_US        = 2_000;
  localparam int unsigned SAMPLE_CYC_DEF = CLK_HZ / SAMPLE_HZ;
  localparam int unsigned WAKE_CYC_DEF   = WAKE_US * (CLK_HZ / 1_000_000);
  // Idle timeout, in sample ticks, indexed by the timeout field
  localparam logic [7:0] TMO_TICKS_0 = 8'h28;
  localparam logic [7:0] TMO_TICKS_1 = 8'h50;
  localparam logic [7:0] TMO_TICKS_2 = 8'h78;
  localparam logic [7:0] TMO_TICKS_3 = 8'ha0;
  // Bus
  localparam logic [6:0] SLAVE_ADDR  = 7'h59;
  localparam logic [3:0] BITS_BYTE   = 4'h8;
  localparam logic [2:0] BIT_LAST    = 3'h7;
  // Register indices
  localparam logic [7:0] STATUS_IDX  = 8'h00;
  localparam logic [7:0] CTRL1_IDX   = 8'h01;
  localparam logic [7:0] CTRL2_IDX   = 8'h02;
  localparam logic [7:0] QUEUE_IDX   = 8'h0b;
  // Fields
  localparam int unsigned FULL_BIT   = 0;
  localparam int unsigned EMPTY_BIT  = 1;
  localparam int unsigned SRC_BIT    = 2;
  localparam int unsigned RST_BIT    = 7;
  localparam int unsigned STBY_BIT   = 6;
  localparam int unsigned FORCE_BIT  = 1;
  localparam logic [7:0] CTRL1_WMASK = 8'h07;
  localparam logic [7:0] CTRL2_WMASK = 8'hce;
  localparam logic [7:0] CTRL1_RST   = 8'h00;
  localparam logic [7:0] CTRL2_RST   = 8'h40;
  localparam logic [3:0] CHIP_ID_DEF = 4'h3; // Arbitrary value
  localparam logic [7:0] MID_CODE    = 8'h00;
  localparam logic [7:0] ONE_CODE    = 8'h01;

  typedef enum logic [3:0] {
    P_IDLE = 4'h1,
    P_WAKE = 4'h2,
    P_PLAY = 4'h4,
    P_RAMP = 4'h8
  } hsf_play_e;

  typedef enum logic [5:0] {
    I_IDLE  = 6'h01,
    I_ADDR  = 6'h02,
    I_REG   = 6'h04,
    I_WDATA = 6'h08,
    I_RDATA = 6'h10,
    I_ACK   = 6'h20
  } hsf_bus_e;
endpackage

// file: logic/hsf_top.sv
`timescale 1ns/1ps
// How it works
// - Brownout detector firing resets every register and state machine.
// - Samples sit in a 100-entry queue of 8-bit bytes.
// - While playing, one sample leaves the queue per 8 kHz tick to the DAC.
// - Bytes written to register 0x0B are pushed into the queue unless standby is set.
// - First sample while idle starts wake-up; 2 ms before first DAC sample.
// - Queue empty for the programmed timeout returns the device to idle.
// - Queue data byte is answered with NAK while the queue is full.
// - Full flag set when all entries hold data; no unplayed sample lost.
// - Multi-byte writes to 0x0B all enter the queue; address stays put.
// - Samples are two's complement; 0x00 is mid-scale.
// - Source select bit routes analog inputs to the amplifier.
// - Gain field still applies in analog mode.
// - In analog mode only the force-enable bit powers boost and amplifier.
// - Bytes travel MSB first and every byte gets an acknowledge bit.
// - SDA fall with SCL high is START, SDA rise with SCL high is STOP.
// - Device answers only slave address 0x59 plus direction bit.
// - Acknowledge drives SDA low for the whole acknowledge clock.
// - Any byte count between START and STOP; STOP ends the transfer.
// - Register address auto-increments after each acknowledged data byte, except for bytes written to 0x0B.
// - Register address byte is acknowledged before any data byte.
// - Queue writes during the failsafe ramp to mid-scale are discarded.
// - Unless standby is set, force-enable starts up at once and keeps power on until cleared.
module hsf_top
  import hsf_pkg::*;
#(
  parameter int unsigned DEPTH      = 100,
  parameter int unsigned SAMPLE_CYC = SAMPLE_CYC_DEF,
  parameter int unsigned WAKE_CYC   = WAKE_CYC_DEF,
  parameter logic [3:0]  CHIP_ID    = CHIP_ID_DEF
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output wire logic       sda_o,
  output logic            sda_oe,
  input  wire logic       brownout_detect,
  input  wire logic       dac_ready,
  output logic [7:0]      dac_code,
  output logic            dac_strobe,
  output logic            boost_en,
  output logic            amp_en,
  output logic            analog_sel,
  output logic [1:0]      amp_gain
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned TW = $clog2(SAMPLE_CYC);
  localparam int unsigned WW = $clog2(WAKE_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus events
  logic [2:0] scl_q, sda_q, bo_q;
  logic       clr;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
      bo_q  <= 3'h0;
    end else begin
      scl_q <= {scl_q[1:0], scl_i};
      sda_q <= {sda_q[1:0], sda_i};
      bo_q  <= {bo_q[1:0], brownout_detect};
    end
  end
  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise  = scl_q[1] & ~scl_q[2];
  assign scl_fall  = ~scl_q[1] & scl_q[2];
  assign bus_start = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  assign bus_stop  = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
  assign sda_o     = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] ctrl1_q, ctrl2_q, ptr_q;
  logic       q_full, q_empty;
  assign clr        = bo_q[1] | ctrl2_q[RST_BIT];
  assign analog_sel = ctrl1_q[SRC_BIT];
  assign amp_gain   = ctrl1_q[1:0];

  function automatic logic [7:0] rd_reg(input logic [7:0] idx);
    case (idx)
      STATUS_IDX: rd_reg = {6'h00, q_empty, q_full};
      CTRL1_IDX:  rd_reg = {1'b0, CHIP_ID, ctrl1_q[2:0]};
      CTRL2_IDX:  rd_reg = ctrl2_q;
      default:    rd_reg = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Serial slave
  hsf_bus_e   bus_q, nxt_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic       byte_end, wr_byte, q_write, q_nak, q_push, reg_wr, ramping;
  logic       standby;
  assign byte_end = scl_fall & (cnt_q == BITS_BYTE) &
                    (bus_q inside {I_ADDR, I_REG, I_WDATA});
  assign wr_byte  = byte_end & (bus_q == I_WDATA);
  assign q_write  = wr_byte & (ptr_q == QUEUE_IDX);
  assign q_nak    = q_write & q_full;
  assign q_push   = q_write & ~q_full & ~ramping & ~standby;
  assign reg_wr   = wr_byte & (ptr_q != QUEUE_IDX);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_q  <= I_IDLE;
      nxt_q  <= I_IDLE;
      cnt_q  <= 4'h0;
      sh_q   <= 8'h00;
      ptr_q  <= 8'h00;
      sda_oe <= 1'b0;
    end else if (clr) begin
      bus_q  <= I_IDLE;
      nxt_q  <= I_IDLE;
      cnt_q  <= 4'h0;
      sda_oe <= 1'b0;
      ptr_q  <= 8'h00;
    end else if (bus_start) begin
      bus_q  <= I_ADDR;
      cnt_q  <= 4'h0;
      sda_oe <= 1'b0;
    end else if (bus_stop) begin
      bus_q  <= I_IDLE;
      sda_oe <= 1'b0;
    end else begin
      unique case (bus_q)
        I_IDLE: ;
        I_ADDR, I_REG, I_WDATA: begin
          if (scl_rise && cnt_q != BITS_BYTE) begin
            sh_q  <= {sh_q[6:0], sda_q[1]};
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_end) begin
            cnt_q <= 4'h0;
            bus_q <= I_ACK;
            if (bus_q == I_ADDR) begin
              if (sh_q[7:1] != SLAVE_ADDR) begin
                bus_q <= I_IDLE;
              end else if (sh_q[0]) begin
                sda_oe <= 1'b1;
                nxt_q  <= I_RDATA;
                sh_q   <= rd_reg(ptr_q);
              end else begin
                sda_oe <= 1'b1;
                nxt_q  <= I_REG;
              end
            end else if (bus_q == I_REG) begin
              ptr_q  <= sh_q;
              sda_oe <= 1'b1;
              nxt_q  <= I_WDATA;
            end else begin
              sda_oe <= ~q_nak;
              nxt_q  <= I_WDATA;
              if (!q_write) begin
                ptr_q <= ptr_q + 8'h01;
              end
            end
          end
        end
        I_ACK: begin
          if (scl_fall) begin
            bus_q  <= nxt_q;
            sda_oe <= (nxt_q == I_RDATA) ? ~sh_q[7] : 1'b0;
          end
        end
        I_RDATA: begin
          if (scl_fall) begin
            if (cnt_q[2:0] == BIT_LAST) begin
              cnt_q  <= 4'h0;
              sda_oe <= 1'b0;
              bus_q  <= I_ADDR;
              nxt_q  <= I_RDATA;
              cnt_q  <= BITS_BYTE;
            end else begin
              cnt_q  <= cnt_q + 4'h1;
              sh_q   <= {sh_q[6:0], 1'b0};
              sda_oe <= ~sh_q[6];
            end
          end
        end
        default: bus_q <= I_IDLE;
      endcase
      // Master acknowledge after a read byte
      if (bus_q == I_ADDR && nxt_q == I_RDATA && cnt_q == BITS_BYTE &&
          scl_rise) begin
        if (!sda_q[1]) begin
          ptr_q <= ptr_q + 8'h01;
          sh_q  <= rd_reg(ptr_q + 8'h01);
          bus_q <= I_ACK;
        end else begin
          bus_q <= I_IDLE;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl1_q <= CTRL1_RST;
      ctrl2_q <= CTRL2_RST;
    end else if (clr) begin
      ctrl1_q <= CTRL1_RST;
      ctrl2_q <= CTRL2_RST;
    end else if (reg_wr && ptr_q == CTRL1_IDX) begin
      ctrl1_q <= sh_q & CTRL1_WMASK;
    end else if (reg_wr && ptr_q == CTRL2_IDX) begin
      ctrl2_q <= sh_q & CTRL2_WMASK;
    end
  end
  assign standby = ctrl2_q[STBY_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Sample queue
  logic [7:0]    mem_q [DEPTH];
  logic [PW-1:0] wp_q, rp_q;
  logic [PW:0]   qc_q;
  logic [1:0]    bc_q;
  logic          pop;
  assign q_full = (qc_q == (PW+1)'(DEPTH));
  assign pop    = (qc_q != '0) & (bc_q != 2'h2);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_q <= '0;
      rp_q <= '0;
      qc_q <= '0;
    end else if (clr) begin
      wp_q <= '0;
      rp_q <= '0;
      qc_q <= '0;
    end else begin
      if (q_push) begin
        mem_q[wp_q] <= sh_q;
        wp_q <= (wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      end
      qc_q <= qc_q + (PW+1)'(q_push) - (PW+1)'(pop);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry buffer in front of the DAC; a stalled DAC loses no word
  logic [7:0] buf_q [2];
  logic       bh_q, drain;
  hsf_play_e  ps_q;
  logic       tick;
  assign drain   = tick & (ps_q == P_PLAY) & (bc_q != 2'h0) & dac_ready;
  assign q_empty = (qc_q == '0) & (bc_q == 2'h0);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bc_q <= 2'h0;
      bh_q <= 1'b0;
    end else if (clr) begin
      bc_q <= 2'h0;
      bh_q <= 1'b0;
    end else begin
      if (pop) begin
        // With one word held the free slot is always the other one
        buf_q[bh_q ^ (bc_q == 2'h1)] <= mem_q[rp_q];
      end
      if (drain) begin
        bh_q <= ~bh_q;
      end
      bc_q <= bc_q + {1'b0, pop} - {1'b0, drain};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample tick and playback
  logic [TW-1:0] div_q;
  logic [WW-1:0] wk_q;
  logic [7:0]    to_q, to_lim;
  logic          force_en, go_digital;
  assign tick       = (div_q == TW'(SAMPLE_CYC - 1));
  assign force_en   = ctrl2_q[FORCE_BIT];
  assign go_digital = ~analog_sel & ~standby;
  assign ramping    = (ps_q == P_RAMP);
  always_comb begin
    unique case (ctrl2_q[3:2])
      2'h0: to_lim = TMO_TICKS_0;
      2'h1: to_lim = TMO_TICKS_1;
      2'h2: to_lim = TMO_TICKS_2;
      2'h3: to_lim = TMO_TICKS_3;
    endcase
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= '0;
    end else if (clr || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ps_q       <= P_IDLE;
      wk_q       <= '0;
      to_q       <= 8'h00;
      dac_code   <= MID_CODE;
      dac_strobe <= 1'b0;
    end else if (clr) begin
      ps_q       <= P_IDLE;
      wk_q       <= '0;
      to_q       <= 8'h00;
      dac_code   <= MID_CODE;
      dac_strobe <= 1'b0;
    end else begin
      dac_strobe <= 1'b0;
      unique case (ps_q)
        P_IDLE: begin
          wk_q <= '0;
          if (go_digital && (q_push || force_en)) begin
            ps_q <= P_WAKE;
          end
        end
        P_WAKE: begin
          wk_q <= wk_q + 1'b1;
          if (!go_digital) begin
            ps_q <= P_IDLE;
          end else if (wk_q == WW'(WAKE_CYC - 1)) begin
            ps_q <= P_PLAY;
            to_q <= 8'h00;
          end
        end
        P_PLAY: begin
          if (!go_digital) begin
            ps_q <= P_IDLE;
          end else if (drain) begin
            dac_code   <= buf_q[bh_q];
            dac_strobe <= 1'b1;
            to_q       <= 8'h00;
          end else if (tick && bc_q == 2'h0 && !force_en) begin
            to_q <= to_q + 8'h01;
            if (to_q == to_lim) begin
              ps_q <= (dac_code == MID_CODE) ? P_IDLE : P_RAMP;
            end
          end
        end
        P_RAMP: begin
          // Step one code per tick; signed compare finds the direction
          if (dac_code == MID_CODE) begin
            ps_q <= P_IDLE;
          end else if (tick) begin
            dac_code   <= $signed(dac_code) > 0 ? dac_code - ONE_CODE
                                                : dac_code + ONE_CODE;
            dac_strobe <= 1'b1;
          end
        end
      endcase
    end
  end

  // Analog mode power follows the force bit, held off while standby is set
  always_comb begin
    if (analog_sel) begin
      boost_en = force_en & ~standby;
    end else begin
      boost_en = (ps_q != P_IDLE);
    end
    amp_en = boost_en;
  end
endmodule

// file: bench/hsf_props.sv
`timescale 1ns/1ps
module hsf_props
  import hsf_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC = SAMPLE_CYC_DEF,
  parameter int unsigned WAKE_CYC   = WAKE_CYC_DEF
) (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  input wire logic       brownout_detect,
  input wire logic       dac_ready,
  input wire logic [7:0] dac_code,
  input wire logic       dac_strobe,
  input wire logic       boost_en,
  input wire logic       amp_en,
  input wire logic       analog_sel,
  input wire logic [1:0] amp_gain
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [15:0] gap_q;
  logic [15:0] on_q;
  // Saturating so long idle spans never wrap
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) gap_q <= 16'hffff;
    else if (dac_strobe) gap_q <= 16'h0000;
    else if (gap_q != 16'hffff) gap_q <= gap_q + 16'h0001;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) on_q <= 16'h0000;
    else if (!boost_en) on_q <= 16'h0000;
    else if (on_q != 16'hffff) on_q <= on_q + 16'h0001;
  end
  a_sda_o_low: assert property (sda_o == 1'b0)
    else $error("sda_o not low");
  a_ack_holds: assert property ($rose(scl_i) && sda_oe |=> sda_oe [*3])
    else $error("ack released during SCL high");
  a_oe_scl_low: assert property ($rose(sda_oe) |-> !$past(scl_i))
    else $error("SDA driven while SCL high");
  a_tick_gap: assert property (dac_strobe |-> gap_q >= SAMPLE_CYC - 1)
    else $error("samples closer than one tick");
  a_wake_wait: assert property (dac_strobe |-> on_q >= WAKE_CYC - 2)
    else $error("sample before wake-up done");
  a_play_power: assert property (dac_strobe |-> boost_en)
    else $error("sample while powered down");
  a_amp_boost: assert property (amp_en == boost_en)
    else $error("amp and boost enables differ");
  a_brown_clear: assert property (brownout_detect [*4] |->
    !boost_en && !sda_oe && dac_code == 8'h00 && amp_gain == 2'h0)
    else $error("brownout did not clear");
  a_code_holds: assert property ($changed(dac_code) |-> dac_strobe ||
    $past(brownout_detect, 2) || $past(brownout_detect, 3))
    else $error("dac code changed without strobe");
  c_ack: cover property ($rose(sda_oe));
  c_play: cover property (dac_strobe && dac_code != 8'h00);
  c_force: cover property ($rose(boost_en) && analog_sel);
endmodule
////////////////////////////////////////////////////////////////////////////
bind hsf_top hsf_props #(.SAMPLE_CYC(SAMPLE_CYC), .WAKE_CYC(WAKE_CYC))
  u_props (.clk(clk), .rst_b(rst_b), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .brownout_detect(brownout_detect),
  .dac_ready(dac_ready), .dac_code(dac_code), .dac_strobe(dac_strobe),
  .boost_en(boost_en), .amp_en(amp_en), .analog_sel(analog_sel),
  .amp_gain(amp_gain));

// file: bench/hsf_host.sv
`timescale 1ns/1ps
module hsf_host (
  input  wire logic clk,
  input  wire logic sda_w,
  output logic      scl,
  output logic      pull
);
  // Released bus floats high on the pull-up
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic hc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic start();
    pull = 1'b1;
    hc(2);
    scl = 1'b0;
    hc(2);
  endtask
  task automatic stop();
    pull = 1'b1;
    hc(2);
    scl = 1'b1;
    hc(2);
    pull = 1'b0;
    hc(4);
  endtask
  // Repeated start from SCL low: release, raise SCL, then START
  task automatic rstart();
    pull = 1'b0;
    hc(2);
    scl = 1'b1;
    hc(2);
    start();
  endtask
  // Data moves only with SCL low; 4 low, 4 high
  task automatic bit_out(input logic b);
    pull = ~b;
    hc(2);
    scl = 1'b1;
    hc(4);
    scl = 1'b0;
    hc(2);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) bit_out(b[i]);
    pull = 1'b0;
    hc(2);
    scl = 1'b1;
    hc(2);
    ack = (sda_w === 1'b0);
    hc(2);
    scl = 1'b0;
    hc(2);
  endtask
  // Reads one byte MSB first, then sends ack (nak low) or NAK
  task automatic rbyte(input logic nak, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      pull = 1'b0;
      hc(2);
      scl = 1'b1;
      hc(2);
      b[i] = sda_w;
      hc(2);
      scl = 1'b0;
      hc(2);
    end
    bit_out(nak);
  endtask
endmodule

// file: bench/hsf_top_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin \
  num_errors++; $display("[ERR] %s exp %h got %h", nm, e, a); end end
module hsf_top_test;
  import hsf_pkg::*;
  localparam int unsigned SC = 20;
  localparam int unsigned WC = 50;
  logic       clk, rst_b, brown, rdy, scl, pull, mon;
  wire logic  sda_w, sda_o, sda_oe, strb, boost, amp, asel;
  wire logic [7:0] code;
  wire logic [1:0] gain;
  logic [7:0] got[$];
  logic [7:0] q[$];
  int         num_errors, n_checks, cyc, n;
  assign sda_w = ~(pull | sda_oe);
  hsf_top #(.SAMPLE_CYC(SC), .WAKE_CYC(WC)) dut (.clk(clk),
    .rst_b(rst_b), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe), .brownout_detect(brown), .dac_ready(rdy),
    .dac_code(code), .dac_strobe(strb), .boost_en(boost), .amp_en(amp),
    .analog_sel(asel), .amp_gain(gain));
  hsf_host host (.clk(clk), .sda_w(sda_w), .scl(scl), .pull(pull));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (strb === 1'b1 && mon) got.push_back(code);
    cyc++;
    // Ceiling well above fill, drain and two timeouts
    if (cyc == 60000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Sends bytes until the first NAK, then STOP; n counts acks
  task automatic wr(input logic [7:0] b[$]);
    logic ack;
    host.start();
    n = 0;
    foreach (b[i]) begin
      host.wbyte(b[i], ack);
      if (!ack) break;
      n++;
    end
    host.stop();
  endtask
  // Two-byte register read: master acks the first byte, NAKs the second
  task automatic rd2(input logic [7:0] idx, output logic [7:0] d0, d1);
    logic ack;
    host.start();
    host.wbyte(8'hb2, ack);
    host.wbyte(idx, ack);
    host.rstart();
    host.wbyte(8'hb3, ack);
    host.rbyte(1'b0, d0);
    host.rbyte(1'b1, d1);
    host.stop();
  endtask
  task automatic t_reset();
    `CHK("boost", 1'b0, boost)
    `CHK("code", 8'h00, code)
    wr('{8'h54, 8'h02, 8'h00});
    `CHK("foreign addr", 0, n)
    wr('{8'hb2, 8'h01, 8'h01, 8'h00});
    `CHK("acks", 4, n)
    `CHK("gain", 2'h1, gain)
  endtask
  task automatic t_wake();
    mon = 1'b1;
    rdy = 1'b1;
    wr('{8'hb2, 8'h0b, 8'h11});
    `CHK("wake", 1'b1, boost)
    for (int i = 0; i < 400 && got.size() == 0; i++) @(negedge clk);
    `CHK("first", 8'h11, got[0])
    for (int i = 0; i < 2500 && boost !== 1'b0; i++) @(negedge clk);
    `CHK("idle", 1'b0, boost)
    `CHK("ramp end", 8'h00, got[$])
  endtask
  task automatic t_fill();
    logic [7:0] st, id;
    got.delete();
    rdy = 1'b0;
    q = '{8'hb2, 8'h0b};
    for (int i = 0; i < 110; i++) q.push_back(8'(i * 3 + 8'h7d));
    wr(q);
    `CHK("accepted", 104, n)
    rd2(STATUS_IDX, st, id);
    `CHK("status full", 8'h01, st)
    `CHK("rd incr", {1'b0, CHIP_ID_DEF, 3'h1}, id)
    rdy = 1'b1;
    for (int i = 0; i < 400 && got.size() == 0; i++) @(negedge clk);
    // Resend from the refused byte once room opens
    wr('{8'hb2, 8'h0b, q[n]});
    `CHK("resend", 3, n)
    for (int i = 0; i < 3000 && got.size() < 103; i++) @(negedge clk);
    `CHK("drained", 103, got.size())
    foreach (got[i]) `CHK("order", q[i + 2], got[i])
    mon = 1'b0;
    for (int i = 0; i < 5000 && boost !== 1'b0; i++) @(negedge clk);
  endtask
  task automatic t_analog();
    wr('{8'hb2, 8'h01, 8'h07});
    `CHK("sel", 1'b1, asel)
    `CHK("gain", 2'h3, gain)
    `CHK("no auto", 1'b0, boost)
    wr('{8'hb2, 8'h02, 8'h02});
    `CHK("force on", 1'b1, boost)
    wr('{8'hb2, 8'h02, 8'h00});
    `CHK("force off", 1'b0, boost)
  endtask
  task automatic t_brown();
    wr('{8'hb2, 8'h01, 8'h03, 8'h02});
    `CHK("forced", 1'b1, boost)
    brown = 1'b1;
    host.hc(6);
    brown = 1'b0;
    host.hc(4);
    `CHK("brown boost", 1'b0, boost)
    `CHK("brown gain", 2'h0, gain)
    `CHK("brown sel", 1'b0, asel)
  endtask
  initial begin
    rst_b = 1'b0;
    brown = 1'b0;
    rdy = 1'b0;
    mon = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    repeat (6) @(negedge clk);
    t_reset();
    t_wake();
    t_fill();
    t_analog();
    t_brown();
    tally_and_finish();
  end
endmodule
